/* File: scwp_pkg.sv */
package scwp_pkg;
    // Frame layout
    localparam int FRAME_BITS = 32;
    localparam int HDR_BITS = 12;
    localparam int ADDR_BITS = 4;
    localparam int DATA_BITS = 16;
    localparam logic [11:0] HDR_PATTERN = 12'h001;
    localparam logic [5:0] FRAME_LAST = 6'h1F;
    localparam logic [5:0] HDR_LAST = 6'h0B;
    // Register addresses
    localparam logic [3:0] ADDR_CAL = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_I_OFFSET = 4'h2;
    localparam logic [3:0] ADDR_I_FULLSCALE = 4'h3;
    localparam logic [3:0] ADDR_EXT_CONFIG = 4'h9;
    localparam logic [3:0] ADDR_Q_OFFSET = 4'hA;
    localparam logic [3:0] ADDR_Q_FULLSCALE = 4'hB;
    localparam logic [3:0] ADDR_PHASE_FINE = 4'hE;
    localparam logic [3:0] ADDR_PHASE_COARSE = 4'hF;
    // Reset values
    localparam logic [15:0] CAL_RESET = 16'h7FFF;
    localparam logic [15:0] CONFIG_RESET = 16'hB2FF;
    localparam logic [15:0] GEN_RESET = 16'h0000;
    localparam int CAL_BIT = 15;
    localparam logic [15:0] CAL_FILL = 16'h7FFF;
    // Host APB register offsets
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_CTRL = 12'h008;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CTRL_HOLD_BIT = 0;
    // Serial clock divider: half period in pclk cycles (160 ns period)
    localparam int SCLK_PERIOD_NS = 160;
    localparam int PCLK_PERIOD_NS = 20;
    localparam logic [3:0] SCLK_HALF = 4'((SCLK_PERIOD_NS / PCLK_PERIOD_NS) / 2);
endpackage : scwp_pkg

/* File: scwp_if.sv */
`timescale 1ns/1ns
interface scwp_if;
    logic sclk; // Serial shift clock, host driven
    logic serial_select_n; // Active low frame select
    logic serial_data_in; // Serial data, MSB first
    modport device (input sclk, input serial_select_n, input serial_data_in);
    modport host (output sclk, output serial_select_n, output serial_data_in);
endinterface : scwp_if

/* File: scwp_device.sv */
`timescale 1ns/1ns
module scwp_device
(
    input wire logic pclk,
    input wire logic presetn,
    scwp_if.device link,
    input wire logic extended_mode, // High selects extended control
    input wire logic power_down, // Converter power-down request
    output logic [15:0] cal_reg_q,
    output logic [15:0] config_q,
    output logic [15:0] i_offset_q,
    output logic [15:0] i_fullscale_q,
    output logic [15:0] ext_config_q,
    output logic [15:0] q_offset_q,
    output logic [15:0] q_fullscale_q,
    output logic [15:0] phase_fine_q,
    output logic [15:0] phase_coarse_q,
    output logic cal_start, // One-cycle calibration request
    output logic power_down_q, // Registered power-down state
    output logic frame_error // One-cycle pulse on a full frame with bad header or reserved address
);
    // Two-flop synchronisers for the pins
    logic [1:0] sclk_s_r;
    logic [1:0] sel_s_r;
    logic [1:0] dat_s_r;
    logic [1:0] ext_s_r;
    logic sclk_d_r; // Previous synced clock for edge find
    logic [5:0] bit_cnt_r; // Bit position in frame
    logic [30:0] shift_r; // Bits received so far
    logic bad_hdr_r; // Header mismatch seen
    logic [15:0] cal_r, cfg_r, ioff_r, ifs_r, ext_r, qoff_r, qfs_r, pf_r, pc_r;
    logic cal_start_r, frame_err_r, pd_r;

    // Decode of synchronised pins
    wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    wire sel_active = ~sel_s_r[1];
    wire ext_on = ext_s_r[1];
    wire take_bit = sclk_rise & sel_active & ext_on;
    wire [31:0] frame = {shift_r, dat_s_r[1]};
    wire hdr_ok_now = (frame[11:0] == scwp_pkg::HDR_PATTERN);
    wire at_hdr_end = (bit_cnt_r == scwp_pkg::HDR_LAST);
    wire at_end = (bit_cnt_r == scwp_pkg::FRAME_LAST);
    wire frame_done = take_bit & at_end;
    wire commit = frame_done & ~bad_hdr_r;
    wire [3:0] waddr = frame[19:16];
    wire [15:0] wdata = frame[15:0];
    wire addr_ok = (waddr == scwp_pkg::ADDR_CAL) | (waddr == scwp_pkg::ADDR_CONFIG) |
        (waddr == scwp_pkg::ADDR_I_OFFSET) | (waddr == scwp_pkg::ADDR_I_FULLSCALE) |
        (waddr == scwp_pkg::ADDR_EXT_CONFIG) | (waddr == scwp_pkg::ADDR_Q_OFFSET) |
        (waddr == scwp_pkg::ADDR_Q_FULLSCALE) | (waddr == scwp_pkg::ADDR_PHASE_FINE) |
        (waddr == scwp_pkg::ADDR_PHASE_COARSE);

    // Write strobe for one address
    function automatic logic hit(input logic [3:0] a);
        hit = commit & (waddr == a);
    endfunction : hit

    // Pin synchronisers; first stage read only by the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_s_r <= 2'h0;
            sel_s_r <= 2'h3;
            dat_s_r <= 2'h0;
            ext_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            sclk_s_r <= {sclk_s_r[0], link.sclk};
            sel_s_r <= {sel_s_r[0], link.serial_select_n};
            dat_s_r <= {dat_s_r[0], link.serial_data_in};
            ext_s_r <= {ext_s_r[0], extended_mode};
            sclk_d_r <= sclk_s_r[1];
        end
    end

    // Frame shifter and bit counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_cnt_r <= 6'h00;
            shift_r <= 31'h0;
            bad_hdr_r <= 1'b0;
        end
        else if (!sel_active || !ext_on)
        begin
            // Select release abandons a partial frame
            bit_cnt_r <= 6'h00;
            bad_hdr_r <= 1'b0;
        end
        else if (take_bit)
        begin
            shift_r <= frame[30:0];
            if (at_end)
            begin
                // Wrap so the next frame starts at bit 0
                bit_cnt_r <= 6'h00;
                bad_hdr_r <= 1'b0;
            end
            else
            begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
                if (at_hdr_end && !hdr_ok_now)
                begin
                    bad_hdr_r <= 1'b1;
                end
            end
        end
    end

    // Register file; power_down never touches it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_r <= scwp_pkg::CAL_RESET;
            cfg_r <= scwp_pkg::CONFIG_RESET;
            ioff_r <= scwp_pkg::GEN_RESET;
            ifs_r <= scwp_pkg::GEN_RESET;
            ext_r <= scwp_pkg::GEN_RESET;
            qoff_r <= scwp_pkg::GEN_RESET;
            qfs_r <= scwp_pkg::GEN_RESET;
            pf_r <= scwp_pkg::GEN_RESET;
            pc_r <= scwp_pkg::GEN_RESET;
        end
        else
        begin
            // Reserved addresses match no strobe
            if (hit(scwp_pkg::ADDR_CAL))
            begin
                cal_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_CONFIG))
            begin
                cfg_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_I_OFFSET))
            begin
                ioff_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_I_FULLSCALE))
            begin
                ifs_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_EXT_CONFIG))
            begin
                ext_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_Q_OFFSET))
            begin
                qoff_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_Q_FULLSCALE))
            begin
                qfs_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_PHASE_FINE))
            begin
                pf_r <= wdata;
            end
            if (hit(scwp_pkg::ADDR_PHASE_COARSE))
            begin
                pc_r <= wdata;
            end
        end
    end

    // Calibration pulse, frame error and power-down state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_start_r <= 1'b0;
            frame_err_r <= 1'b0;
            pd_r <= 1'b0;
        end
        else
        begin
            cal_start_r <= hit(scwp_pkg::ADDR_CAL) & wdata[scwp_pkg::CAL_BIT];
            frame_err_r <= (frame_done & bad_hdr_r) | (commit & ~addr_ok);
            pd_r <= power_down;
        end
    end

    // All outputs straight from flops
    assign cal_reg_q = cal_r;
    assign config_q = cfg_r;
    assign i_offset_q = ioff_r;
    assign i_fullscale_q = ifs_r;
    assign ext_config_q = ext_r;
    assign q_offset_q = qoff_r;
    assign q_fullscale_q = qfs_r;
    assign phase_fine_q = pf_r;
    assign phase_coarse_q = pc_r;
    assign cal_start = cal_start_r;
    assign frame_error = frame_err_r;
    assign power_down_q = pd_r;
endmodule : scwp_device

/* File: scwp_host.sv */
`timescale 1ns/1ns
// APB-controlled host that serialises one register write per command
module scwp_host
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cal_busy, // Converter calibrating
    scwp_if.host link
);
    typedef enum {SCWP_IDLE, SCWP_LOW, SCWP_HIGH, SCWP_GAP} scwp_state_t;
    scwp_state_t st_r;
    logic [31:0] frame_r; // Frame being shifted out
    logic [5:0] cnt_r; // Bits left
    logic [3:0] div_r; // Half-period counter
    logic sclk_r, sel_n_r, sd_r;
    logic pend_r; // Command waiting to start
    logic [31:0] cmd_r; // Queued frame
    logic hold_r; // Keep select low between frames
    logic [31:0] prdata_r;
    logic pready_r;

    // APB decode; one wait state, answer registered
    wire access = psel & penable & ~pready_r;
    // Writes land only at the edge that completes the transfer, with pready high
    wire done = psel & penable & pready_r;
    wire wr_cmd = done & pwrite & (paddr == scwp_pkg::OFS_CMD);
    wire wr_ctrl = done & pwrite & (paddr == scwp_pkg::OFS_CTRL);
    wire busy = pend_r | (st_r != SCWP_IDLE);
    wire [31:0] status_word = {30'h0, cal_busy, busy};
    wire [31:0] ctrl_word = {31'h0, hold_r};
    wire [31:0] rd_mux = (paddr == scwp_pkg::OFS_STATUS) ? status_word :
        (paddr == scwp_pkg::OFS_CTRL) ? ctrl_word : 32'h0;
    wire mapped = (paddr == scwp_pkg::OFS_CMD) | (paddr == scwp_pkg::OFS_STATUS) | (paddr == scwp_pkg::OFS_CTRL);
    // Frame: header, address in cmd[19:16], data in cmd[15:0]
    wire [31:0] new_frame = {scwp_pkg::HDR_PATTERN, pwdata[scwp_pkg::CMD_ADDR_LSB +: 4], pwdata[15:0]};
    wire half_done = (div_r == scwp_pkg::SCLK_HALF - 4'h1);

    // APB slave
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            hold_r <= 1'b0;
        end
        else
        begin
            pready_r <= access;
            prdata_r <= access ? rd_mux : 32'h0;
            if (wr_ctrl)
            begin
                hold_r <= pwdata[scwp_pkg::CTRL_HOLD_BIT];
            end
        end
    end

    // Frame engine; commands during busy or calibration are dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= SCWP_IDLE;
            frame_r <= 32'h0;
            cnt_r <= 6'h00;
            div_r <= 4'h0;
            sclk_r <= 1'b0;
            sel_n_r <= 1'b1;
            sd_r <= 1'b0;
            pend_r <= 1'b0;
            cmd_r <= 32'h0;
        end
        else
        begin
            if (wr_cmd && !busy && !cal_busy)
            begin
                pend_r <= 1'b1;
                cmd_r <= new_frame;
            end
            case (st_r)
                SCWP_IDLE:
                begin
                    // Hold only keeps select low once a frame pulled it low; it never falls with no clock
                    sel_n_r <= sel_n_r | ~hold_r;
                    if (pend_r)
                    begin
                        // Data set half a period before first rise
                        pend_r <= 1'b0;
                        frame_r <= {cmd_r[30:0], 1'b0};
                        sd_r <= cmd_r[31];
                        sel_n_r <= 1'b0;
                        cnt_r <= 6'(scwp_pkg::FRAME_BITS);
                        div_r <= 4'h0;
                        st_r <= SCWP_LOW;
                    end
                end
                SCWP_LOW:
                begin
                    div_r <= half_done ? 4'h0 : div_r + 4'h1;
                    if (half_done)
                    begin
                        sclk_r <= 1'b1;
                        cnt_r <= cnt_r - 6'h01;
                        st_r <= SCWP_HIGH;
                    end
                end
                SCWP_HIGH:
                begin
                    div_r <= half_done ? 4'h0 : div_r + 4'h1;
                    if (half_done)
                    begin
                        sclk_r <= 1'b0;
                        sd_r <= frame_r[31];
                        frame_r <= {frame_r[30:0], 1'b0};
                        st_r <= (cnt_r == 6'h00) ? SCWP_GAP : SCWP_LOW;
                    end
                end
                SCWP_GAP:
                begin
                    // Hold select through the last clock low phase
                    div_r <= half_done ? 4'h0 : div_r + 4'h1;
                    if (half_done)
                    begin
                        sel_n_r <= ~hold_r;
                        st_r <= SCWP_IDLE;
                    end
                end
                default:
                begin
                    st_r <= SCWP_IDLE;
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = 1'b0 & mapped;
    assign link.sclk = sclk_r;
    assign link.serial_select_n = sel_n_r;
    assign link.serial_data_in = sd_r;
endmodule : scwp_host

/* File: scwp_checker.sv */
`timescale 1ns/1ns
// Watches the serial wire between the host end and the device end
module scwp_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic serial_data_in
);
    logic sclk_d_r; // Serial clock one cycle ago
    logic [4:0] rise_cnt_r; // Rises seen in this frame, wraps at 32
    logic [4:0] rise_cnt_nxt;
    wire sclk_rise; // Serial clock rising this cycle
    assign sclk_rise = sclk && !sclk_d_r;
    // Deselect clears the count; the wrap restarts header checks for chained frames
    assign rise_cnt_nxt = serial_select_n ? 5'h00 : (sclk_rise ? rise_cnt_r + 5'h01 : rise_cnt_r);
    // Edge and bit tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_d_r <= 1'b0;
            rise_cnt_r <= 5'h00;
        end
        else
        begin
            sclk_d_r <= sclk;
            rise_cnt_r <= rise_cnt_nxt;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_IDLE_CLOCK_LOW: assert property (serial_select_n |-> !sclk)
        else $error("serial clock high while deselected");
    AST_HIGH_PHASE: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    AST_LOW_PHASE: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("serial clock low phase too short");
    AST_DATA_STABLE: assert property (sclk |-> $stable(serial_data_in))
        else $error("serial data moved while clock high");
    AST_SELECT_LEAD: assert property ($fell(serial_select_n) |-> !sclk [*2] ##[1:8] sclk_rise)
        else $error("no first clock soon after select");
    AST_HDR_ZEROS: assert property (sclk_rise && rise_cnt_r < 5'h0B |-> !serial_data_in)
        else $error("header zero bit wrong");
    AST_HDR_ONE: assert property (sclk_rise && rise_cnt_r == 5'h0B |-> serial_data_in)
        else $error("header final one bit wrong");
    AST_WHOLE_FRAME: assert property ($rose(serial_select_n) |-> rise_cnt_r == 5'h00 && !$past(sclk))
        else $error("select released inside a frame");
endmodule : scwp_checker

/* File: serial_config_write_port_tb_top.sv */
`timescale 1ns/1ns
// Host and device joined on one link; a second device is driven directly
module serial_config_write_port_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd; // Last APB read data
    logic slverr; // Last APB error flag
    logic pready;
    logic pslverr;
    logic cal_busy = 1'b0;
    logic extended_mode = 1'b1;
    logic power_down = 1'b0;
    logic [15:0] q [0:15]; // Device outputs by register address
    logic [15:0] exp_q [0:15]; // Expected contents
    logic cal_start, power_down_q, frame_error, ferr2;
    logic [15:0] off2, fs2, r1, r2, r3;
    logic [3:0] ra;
    logic [7:0] n_cal = 8'h00, n_err = 8'h00, n_err2 = 8'h00, x_cal = 8'h00, x_err = 8'h00;
    int errors = 0;
    int cmp_count = 0;
    scwp_if lnk();
    scwp_if lnk2();
    scwp_host i_scwp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cal_busy(cal_busy), .link(lnk));
    scwp_device i_scwp_device (.pclk(pclk), .presetn(presetn), .link(lnk), .extended_mode(extended_mode),
        .power_down(power_down), .cal_reg_q(q[0]), .config_q(q[1]), .i_offset_q(q[2]), .i_fullscale_q(q[3]),
        .ext_config_q(q[9]), .q_offset_q(q[10]), .q_fullscale_q(q[11]), .phase_fine_q(q[14]),
        .phase_coarse_q(q[15]), .cal_start(cal_start), .power_down_q(power_down_q), .frame_error(frame_error));
    // Second device: fed by the bench so bad frames can be sent
    scwp_device i_scwp_device_2 (.pclk(pclk), .presetn(presetn), .link(lnk2), .extended_mode(1'b1),
        .power_down(1'b0), .cal_reg_q(), .config_q(), .i_offset_q(off2), .i_fullscale_q(fs2), .ext_config_q(),
        .q_offset_q(), .q_fullscale_q(), .phase_fine_q(), .phase_coarse_q(), .cal_start(), .power_down_q(),
        .frame_error(ferr2));
    scwp_checker u_chk (.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .serial_select_n(lnk.serial_select_n),
        .serial_data_in(lnk.serial_data_in));
    // 50 MHz clock
    always #10 pclk = ~pclk;
    // Pulse counters
    always @(posedge pclk)
    begin
        n_cal += 8'(cal_start === 1'b1);
        n_err += 8'(frame_error === 1'b1);
        n_err2 += 8'(ferr2 === 1'b1);
    end
    function automatic logic valid_addr(input logic [3:0] a);
        return !(a inside {[4'h4:4'h8], 4'hC, 4'hD});
    endfunction : valid_addr
    task automatic cmp_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_reg
    task automatic cmp_cnt(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s count expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_cnt
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // One APB transfer; the first edge keeps release and next setup apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready going high ends this wait; the watchdog catches a hang
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Command one serial write, wait for the host to go idle, update the model
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        logic acc;
        acc = extended_mode && !cal_busy;
        apb(1'b1, scwp_pkg::OFS_CMD, {12'h000, a, d});
        apb(1'b0, scwp_pkg::OFS_STATUS, 32'h00000000);
        while (rd[0] !== 1'b0)
            apb(1'b0, scwp_pkg::OFS_STATUS, 32'h00000000);
        repeat (4) @(posedge pclk); // Register lands about three cycles after the last rise
        if (acc && valid_addr(a))
            exp_q[a] = d;
        x_err += 8'(acc && !valid_addr(a));
        x_cal += 8'(acc && a == scwp_pkg::ADDR_CAL && d[scwp_pkg::CAL_BIT]);
    endtask : wr_reg
    task automatic chk_all;
        for (int a = 0; a < 16; a++)
            if (valid_addr(4'(a)))
                cmp_reg("register", exp_q[a], q[a]);
        cmp_cnt("cal_start", x_cal, n_cal);
        cmp_cnt("frame_error", x_err, n_err);
    endtask : chk_all
    // Raw frames on the second link: n bits from the top, with random pauses
    task automatic frame2(input logic [63:0] w, input int n);
        lnk2.serial_select_n <= 1'b0;
        for (int i = 63; i > 63 - n; i--)
        begin
            lnk2.serial_data_in <= w[i];
            repeat (4 + (($urandom % 8 == 0) ? $urandom % 40 : 0)) @(posedge pclk);
            lnk2.sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            lnk2.sclk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        lnk2.serial_select_n <= 1'b1;
        lnk2.serial_data_in <= ~w[64 - n]; // Released line shows the inverse
        repeat (8) @(posedge pclk);
    endtask : frame2
    // Hang guard
    initial
    begin
        #1000000;
        errors++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        lnk2.sclk = 1'b0;
        lnk2.serial_select_n = 1'b1;
        lnk2.serial_data_in = 1'b0;
        for (int a = 0; a < 16; a++)
            exp_q[a] = (a == 0) ? scwp_pkg::CAL_RESET : (a == 1) ? scwp_pkg::CONFIG_RESET : scwp_pkg::GEN_RESET;
        r1 = 16'($urandom(32'h4528));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk_all();
        apb(1'b0, 12'h00C, 32'h00000000);
        cmp_reg("unmapped", 16'h0000, rd[15:0]);
        cmp_reg("pslverr", 16'h0000, {15'h0000, slverr});
        // Initial full load, then random traffic that keeps calibration fill bits
        for (int a = 0; a < 16; a++)
            if (valid_addr(4'(a)))
                wr_reg(4'(a), (a == 0) ? scwp_pkg::CAL_FILL : 16'($urandom));
        wr_reg(scwp_pkg::ADDR_CAL, 16'hFFFF);
        repeat (20)
        begin
            ra = 4'($urandom);
            wr_reg(ra, (ra == scwp_pkg::ADDR_CAL) ? {1'($urandom), 15'h7FFF} : 16'($urandom));
        end
        chk_all();
        // Select held low across chained frames
        apb(1'b1, scwp_pkg::OFS_CTRL, 32'h00000001);
        apb(1'b0, scwp_pkg::OFS_CTRL, 32'h00000000);
        cmp_reg("hold", 16'h0001, rd[15:0]);
        wr_reg(scwp_pkg::ADDR_Q_OFFSET, 16'($urandom));
        wr_reg(scwp_pkg::ADDR_PHASE_FINE, 16'($urandom));
        apb(1'b1, scwp_pkg::OFS_CTRL, 32'h00000000);
        chk_all();
        // Power-down keeps contents
        power_down <= 1'b1;
        repeat (4) @(posedge pclk);
        cmp_reg("power_down_q", 16'h0001, {15'h0000, power_down_q});
        power_down <= 1'b0;
        repeat (4) @(posedge pclk);
        chk_all();
        // Normal mode ignores the link
        extended_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        wr_reg(scwp_pkg::ADDR_CONFIG, ~exp_q[1]);
        chk_all();
        extended_mode <= 1'b1;
        // Commands are refused during calibration
        cal_busy <= 1'b1;
        apb(1'b0, scwp_pkg::OFS_STATUS, 32'h00000000);
        cmp_reg("status", 16'h0002, rd[15:0]);
        wr_reg(scwp_pkg::ADDR_I_OFFSET, ~exp_q[2]);
        chk_all();
        cal_busy <= 1'b0;
        // Second link: good, bad header, truncated, chained
        r2 = 16'($urandom);
        r3 = 16'($urandom);
        frame2({scwp_pkg::HDR_PATTERN, scwp_pkg::ADDR_I_OFFSET, r1, 32'h00000000}, 32);
        cmp_reg("offset2", r1, off2);
        frame2({12'h801, scwp_pkg::ADDR_I_OFFSET, ~r1, 32'h00000000}, 32);
        cmp_reg("offset2", r1, off2);
        frame2({scwp_pkg::HDR_PATTERN, scwp_pkg::ADDR_I_FULLSCALE, r2, 32'h00000000}, 20);
        cmp_reg("fullscale2", 16'h0000, fs2);
        frame2({scwp_pkg::HDR_PATTERN, scwp_pkg::ADDR_I_OFFSET, r3, scwp_pkg::HDR_PATTERN,
            scwp_pkg::ADDR_I_FULLSCALE, r2}, 64);
        cmp_reg("offset2", r3, off2);
        cmp_reg("fullscale2", r2, fs2);
        cmp_cnt("frame_error2", 8'h01, n_err2);
        wrap_up();
    end
endmodule : serial_config_write_port_tb_top
